// >>> tb/mrc_board.sv
// Board reset source driving the active-low reset pin
`timescale 1ns/1ns
module mrc_board #(
  parameter int LOW_CYCLES = 30
) (
  // Clock and request
  input wire logic sys_clk_i,
  input wire logic go_i,
  // Reset pin
  output logic hw_rst_n_o
);
  int cnt = 0;
  always @(posedge sys_clk_i) begin
    if (go_i) begin
      cnt <= LOW_CYCLES;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign hw_rst_n_o = (cnt == 0);
endmodule

// >>> tb/testbench.sv
// Testbench for the multichannel reset controller
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench
  import mrc_pkg::*;
;
  logic sys_clk = 0;
  logic rst_i = 1;
  logic glb = 0;
  logic go = 0;
  logic hw_n;
  logic common_rst;
  logic s0;
  logic s1;
  logic [10:0] e;
  logic [1:0] ch_rst;
  logic [1:0] std_m;
  logic [1:0] irq_m;
  logic [1:0][7:0] rd;
  mrc_wr_s [1:0] wr = '0;
  logic [10:0] exp_q[$];
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 34;
  event smp;
  wire logic [10:0] obs = {std_m, common_rst, ch_rst, irq_m, rd[1][1:0], rd[0][1:0]};
  always #20 sys_clk = ~sys_clk;
  mrc_board brd (.sys_clk_i(sys_clk), .go_i(go), .hw_rst_n_o(hw_n));
  mrc_top #(.CHANNELS(2), .POR_CYCLES(20)) uut (.sys_clk_i(sys_clk), .rst_i(rst_i), .hw_rst_n_i(hw_n),
    .glb_rst_wr_i(glb), .channel_configuration_wr_i(wr), .channel_configuration_rd_o(rd), .common_rst_o(common_rst), .ch_rst_o(ch_rst),
    .line_standard_select_o(std_m), .ch_irq_mask_o(irq_m));
  task automatic give_verdict();
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Expected snapshot after n falling edges
  task automatic note(input logic [10:0] v, input int n);
    repeat (n) @(negedge sys_clk);
    exp_q.push_back(v);
    -> smp;
  endtask
  always @(smp) begin
    e = exp_q.pop_front();
    `CHK("outputs", e, obs)
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    s0 = $random(seed);
    s1 = $random(seed);
    repeat (4) @(negedge sys_clk);
    rst_i = 0;
    repeat (100) if (common_rst !== 1'b0) @(negedge sys_clk);
    note(11'h000, 0);
    wr[0] = {1'b1, 6'h00, 1'b1, s0};
    wr[1] = {1'b1, 7'h00, s1};
    note({s1, s0, 5'b00101, 1'b0, s1, 1'b1, s0}, 1);
    wr = '0;
    note({s1, s0, 5'b00000, 1'b0, s1, 1'b0, s0}, 21);
    glb = 1;
    @(negedge sys_clk);
    glb = 0;
    note(11'h000, 25);
    wr[1] = {1'b1, 8'h01};
    @(negedge sys_clk);
    wr = '0;
    note(11'h404, 0);
    go = 1;
    @(negedge sys_clk);
    go = 0;
    note(11'h1f0, 10);
    note(11'h000, 30);
    give_verdict();
  end
endmodule

// >>> verilog/mrc_cfg.svh
// Constants for the multichannel reset controller
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH
`define MRC_CLK_MHZ 25
`define MRC_POR_MAX_US 1000
`define MRC_POR_CYCLES ((`MRC_POR_MAX_US * `MRC_CLK_MHZ) - 16)
`define MRC_POR_LIMIT_CYCLES (`MRC_POR_MAX_US * `MRC_CLK_MHZ)
`define MRC_SOFT_MAX_US 1
`define MRC_SOFT_CYCLES ((`MRC_SOFT_MAX_US * `MRC_CLK_MHZ) - 4)
`define MRC_SOFT_LIMIT_CYCLES (`MRC_SOFT_MAX_US * `MRC_CLK_MHZ)
`define MRC_HW_MIN_US 1
`define MRC_HW_MIN_CYCLES (`MRC_HW_MIN_US * `MRC_CLK_MHZ)
`define MRC_CHANNEL_CONFIGURATION_STD_BIT 0
`define MRC_CHANNEL_CONFIGURATION_RST_BIT 1
`define MRC_CHANNEL_CONFIGURATION_RESET 8'h00
`endif

// >>> verilog/mrc_channel.sv
// One channel: configuration register and its own software reset
`timescale 1ns/1ns
`include "mrc_cfg.svh"
module mrc_channel
  import mrc_pkg::*;
#(
  parameter int SOFT_CYCLES = `MRC_SOFT_CYCLES
) (
  // Clock and device-wide reset
  input wire logic sys_clk_i,
  input wire logic glb_rst_i,
  // Register access
  input wire mrc_wr_s cfg_wr_i,
  output logic [7:0] cfg_rd_o,
  // Channel reset and mode
  output logic ch_rst_o,
  output logic line_standard_select_o
);
  localparam logic [7:0] CFG_RESET = `MRC_CHANNEL_CONFIGURATION_RESET;
  logic std_q, std_d;
  logic busy_q, busy_d;
  logic [7:0] cnt_q, cnt_d;

  always_comb begin
    std_d = std_q;
    busy_d = busy_q;
    cnt_d = cnt_q;
    if (busy_q) begin
      if (cnt_q == 8'(SOFT_CYCLES - 1)) begin
        busy_d = 1'b0;
        cnt_d = 8'h00;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
    if (cfg_wr_i.wr) begin
      std_d = cfg_wr_i.data[`MRC_CHANNEL_CONFIGURATION_STD_BIT];
      if (cfg_wr_i.data[`MRC_CHANNEL_CONFIGURATION_RST_BIT] && !busy_q) begin
        busy_d = 1'b1;
        cnt_d = 8'h00;
      end
    end
  end

  // mode bit cleared by a device-wide reset or loaded by a register write, never changed by channel reset
  always_ff @(posedge sys_clk_i) begin
    if (glb_rst_i) begin
      std_q <= CFG_RESET[`MRC_CHANNEL_CONFIGURATION_STD_BIT];
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      std_q <= std_d;
      busy_q <= busy_d;
      cnt_q <= cnt_d;
    end
  end

  assign cfg_rd_o = {6'h00, busy_q, std_q};
  assign ch_rst_o = glb_rst_i | busy_q;
  assign line_standard_select_o = std_q;

  a_soft_self_clear: assert property (@(posedge sys_clk_i) disable iff (glb_rst_i)
    $rose(busy_q) |-> ##[1:25] !busy_q)
    else $error("channel reset did not clear in time");
  a_mode_kept: assert property (@(posedge sys_clk_i) disable iff (glb_rst_i)
    !$past(cfg_wr_i.wr) && !$past(glb_rst_i) |-> $stable(std_q))
    else $error("mode bit changed by channel reset");
endmodule

// >>> verilog/mrc_pkg.sv
// Types for the multichannel reset controller
package mrc_pkg;
  typedef enum logic [1:0] {MRC_POR, MRC_HOLD, MRC_SOFT, MRC_RUN} mrc_state_e;
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } mrc_wr_s;
endpackage

// >>> verilog/mrc_top.sv
// Multichannel reset controller: power-on, pin, global and channel resets
// Notes on behaviour
// - With the clock running, power-on reset ends within 1 ms.
// - Without a clock no logic advances, so power-on reset never finishes.
// - A low reset pin starts a whole-device reset.
// - While the reset pin is low the device stays in reset.
// - A global reset register write while running starts a global reset ending within 1 us.
// - Writing one to the channel soft-reset bit resets that channel only.
// - A channel reset ends within 1 us and its bit self clears.
// - A channel reset keeps the line-standard bit.
// - A channel reset leaves global registers, shared logic and pins alone.
// - A channel reset leaves other channels alone.
// - Device-wide resets reset common blocks and all channels.
// - Device-wide resets mask all interrupts; channel reset masks its own.
// - Resets restore register defaults, the mode bit excepted for channel reset.
`timescale 1ns/1ns
`include "mrc_cfg.svh"
module mrc_top
  import mrc_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int POR_CYCLES = `MRC_POR_CYCLES
) (
  // Clock and power-on
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Board reset pin
  input wire logic hw_rst_n_i,
  // Register writes
  input wire logic glb_rst_wr_i,
  input wire mrc_wr_s [CHANNELS-1:0] channel_configuration_wr_i,
  // Readback, resets, line-standard modes and interrupt masks
  output logic [CHANNELS-1:0][7:0] channel_configuration_rd_o,
  output logic common_rst_o,
  output logic [CHANNELS-1:0] ch_rst_o,
  output logic [CHANNELS-1:0] line_standard_select_o,
  output logic [CHANNELS-1:0] ch_irq_mask_o
);
  mrc_state_e state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic rst_q, rst_d;
  logic [15:0] por_age_q, por_age_d;
  logic [4:0] soft_age_q, soft_age_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      // power-on count, needs the clock to advance
      MRC_POR: begin
        if (cnt_q == 16'(POR_CYCLES - 1)) begin
          // A pin held low across power-on goes straight to the pin hold
          if (hw_rst_n_i) begin
            state_d = MRC_RUN;
          end else begin
            state_d = MRC_HOLD;
          end
          cnt_d = 16'h0000;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      MRC_HOLD: begin
        if (hw_rst_n_i) begin
          state_d = MRC_RUN;
        end
      end
      MRC_SOFT: begin
        if (cnt_q == 16'(`MRC_SOFT_CYCLES - 1)) begin
          state_d = MRC_RUN;
          cnt_d = 16'h0000;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      MRC_RUN: begin
        if (glb_rst_wr_i) begin
          state_d = MRC_SOFT;
          cnt_d = 16'h0000;
        end
      end
    endcase
    if (!hw_rst_n_i && state_q != MRC_POR) begin
      state_d = MRC_HOLD;
      cnt_d = 16'h0000;
    end
    rst_d = (state_d != MRC_RUN);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= MRC_POR;
      cnt_q <= 16'h0000;
      rst_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rst_q <= rst_d;
    end
  end

  // Ages of the timed reset phases, for the assertions only; counters are
  // used because a delay range as long as the power-on bound is too costly
  always_comb begin
    por_age_d = por_age_q;
    soft_age_d = 5'h00;
    if (state_q == MRC_POR && por_age_q != 16'hffff) begin
      por_age_d = por_age_q + 16'h0001;
    end
    if (state_q == MRC_SOFT && soft_age_q != 5'h1f) begin
      soft_age_d = soft_age_q + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      por_age_q <= 16'h0000;
      soft_age_q <= 5'h00;
    end else begin
      por_age_q <= por_age_d;
      soft_age_q <= soft_age_d;
    end
  end

  // common blocks follow device-wide reset only
  // channel resets never reach common reset
  assign common_rst_o = rst_q;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      mrc_channel u_ch (
        .sys_clk_i(sys_clk_i),
        .glb_rst_i(rst_q),
        .cfg_wr_i(channel_configuration_wr_i[g]),
        .cfg_rd_o(channel_configuration_rd_o[g]),
        .ch_rst_o(ch_rst_o[g]),
        .line_standard_select_o(line_standard_select_o[g])
      );
      assign ch_irq_mask_o[g] = ch_rst_o[g];
      a_other_ch_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i || rst_q)
        !channel_configuration_wr_i[g].wr |=> $stable(line_standard_select_o[g]))
        else $error("channel mode changed without its own write");
    end
  endgenerate

  // Named steps of the global and pin resets
  sequence s_glb_request;
    state_q == MRC_RUN && glb_rst_wr_i && hw_rst_n_i;
  endsequence

  sequence s_glb_span;
    rst_q ##[1:25] !rst_q;
  endsequence

  sequence s_pin_release;
    state_q == MRC_HOLD && hw_rst_n_i;
  endsequence

  a_por_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == MRC_POR |-> por_age_q < 16'(`MRC_POR_LIMIT_CYCLES))
    else $error("power-on reset too long");

  a_pin_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !hw_rst_n_i && state_q == MRC_RUN |=> state_q == MRC_HOLD && rst_q)
    else $error("pin low did not start reset");

  a_pin_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !hw_rst_n_i && state_q != MRC_POR |=> rst_q)
    else $error("released while pin low");

  a_pin_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_pin_release |=> !rst_q && state_q == MRC_RUN)
    else $error("not released after pin went high");

  a_glb_soft: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_glb_request |=> s_glb_span)
    else $error("global soft reset wrong length");

  a_glb_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == MRC_SOFT |-> soft_age_q < 5'(`MRC_SOFT_LIMIT_CYCLES))
    else $error("global soft reset too long");

  a_common_iso: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == MRC_RUN && !glb_rst_wr_i && hw_rst_n_i |=> state_q == MRC_RUN && !common_rst_o)
    else $error("common reset without device reset");

  a_all_ch_rst: assert property (@(posedge sys_clk_i)
    rst_q |-> (&ch_rst_o) && (&ch_irq_mask_o))
    else $error("channel not reset with device");

  a_reset_defaults: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rst_q |=> channel_configuration_rd_o == '0)
    else $error("register not at default after device reset");

  a_sync_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(common_rst_o) |-> state_q == MRC_RUN && ch_rst_o == '0)
    else $error("channels left reset on different edges");
endmodule
